// file: verilog/ussc_top.sv
// Serial port status and control: transmit and receive shifters, buffers,
// interrupt event selection, break generation, pin ownership and polarity
// Assumes serial_in is synchronous to sys_clk and one register access a cycle
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns

// Notes on behaviour
// RQ1: Select 00: event on every buffer-to-shifter move
// RQ2: Select 01: event when last character fully sent
// RQ3: Select 10: event when a move empties buffer
// RQ4: Software never writes transmit select 11
// RQ5: Plain output idles high, low when inverted
// RQ6: Encoded output idles low, high when inverted
// RQ7: Break frame: start, twelve zeros, stop
// RQ8: Break bit self-clears once break is sent
// RQ9: Transmit enable gives pin to serial logic
// RQ10: Disable aborts, flushes buffer, releases pin
// RQ11: Buffer full flag reads one when full
// RQ12: Empty flag one when shifter and buffer empty
// RQ13: Empty flag zero while sending or queued
// RQ14: Select 11: event when buffer reaches four
// RQ15: Select 10: event when buffer reaches three
// RQ16: Select 0x: event on every received character
// RQ17: Bit twelve always reads zero
// RQ18: Full and empty flags track occupancy continuously
module ussc_top import ussc_pkg::*; #(
	parameter int CLKS = CLKS_PER_BIT,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_W-1:0] reg_rdata,
	// Serial line
	output logic serial_out_pin,
	output logic serial_out_en,
	input wire logic serial_in,
	// Events
	output logic tx_irq,
	output logic rx_irq
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int PH_W = $clog2(CLKS);
	localparam int IR_RAW = (CLKS * IR_NUM) / IR_DEN;
	localparam int IR_CLKS = (IR_RAW < 1) ? 1 : IR_RAW;
	localparam int BIT_W = 4;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [1:0] tx_sel_q;
	logic inv_q;
	logic brk_q;
	logic txen_q;
	logic [1:0] rx_sel_q;
	logic ir_on_q;
	logic oerr_q;
	logic ferr_q;

	logic wr_status;
	logic wr_txdata;
	logic wr_mode;
	logic rd_rxdata;

	assign wr_status = reg_wr && (reg_addr == REG_STATUS);
	assign wr_txdata = reg_wr && (reg_addr == REG_TXDATA);
	assign wr_mode = reg_wr && (reg_addr == REG_MODE);
	assign rd_rxdata = reg_rd && (reg_addr == REG_RXDATA);

	// ----------------------------------------
	// Transmit buffer
	// ----------------------------------------
	logic tx_push;
	logic tx_pop;
	logic tx_load;
	logic [DATA_W-1:0] tx_head;
	logic [CNT_W-1:0] tx_cnt;
	logic tx_full;
	logic tx_empty;
	logic [CNT_W-1:0] tx_cnt_after;

	assign tx_push = clk_en && wr_txdata && txen_q && !tx_full;

	ussc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.CNT_W(CNT_W)
	) u_tx_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.flush(!txen_q), // RQ10
		.push(tx_push),
		.wdata(reg_wdata[DATA_W-1:0]),
		.pop(tx_pop),
		.rdata(tx_head),
		.count(tx_cnt),
		.full(tx_full),
		.empty(tx_empty)
	);

	assign tx_cnt_after = tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);

	// ----------------------------------------
	// Transmit shifter
	// ----------------------------------------
	ussc_state_t tx_state_q;
	logic [DATA_W-1:0] tx_shift_q;
	logic [BIT_W-1:0] tx_bit_q;
	logic tx_brk_frame_q;
	logic tx_tick;
	logic [PH_W-1:0] tx_phase;
	logic tx_done;
	logic [BIT_W-1:0] tx_last_bit;

	assign tx_load = clk_en && txen_q && (tx_state_q == ST_IDLE) && (brk_q || !tx_empty);
	assign tx_pop = tx_load && !brk_q;
	assign tx_done = (tx_state_q == ST_STOP) && tx_tick;
	assign tx_last_bit = tx_brk_frame_q ? BIT_W'(BREAK_ZEROS - 1) : BIT_W'(DATA_W - 1);

	ussc_baud #(
		.CLKS(CLKS),
		.CNT_W(PH_W)
	) u_tx_baud (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.restart(tx_load),
		.bit_tick(tx_tick),
		.half_tick(),
		.phase(tx_phase)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_q <= ST_IDLE;
			tx_shift_q <= '0;
			tx_bit_q <= '0;
			tx_brk_frame_q <= 1'b0;
		end else if (clk_en) begin
			if (!txen_q) begin
				tx_state_q <= ST_IDLE; // RQ10
				tx_brk_frame_q <= 1'b0;
			end else begin
				case (tx_state_q)
					ST_IDLE: begin
						if (tx_load) begin
							tx_state_q <= ST_START;
							tx_shift_q <= brk_q ? '0 : tx_head; // RQ7
							tx_brk_frame_q <= brk_q;
						end
					end
					ST_START: begin
						if (tx_tick) begin
							tx_state_q <= ST_BITS;
							tx_bit_q <= '0;
						end
					end
					ST_BITS: begin
						if (tx_tick) begin
							tx_shift_q <= tx_shift_q >> 1;
							if (tx_bit_q == tx_last_bit) begin
								tx_state_q <= ST_STOP; // RQ7
							end else begin
								tx_bit_q <= tx_bit_q + 1'b1;
							end
						end
					end
					ST_STOP: begin
						if (tx_tick) begin
							tx_state_q <= ST_IDLE;
							tx_brk_frame_q <= 1'b0;
						end
					end
					default: begin
						tx_state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Output pin: polarity, encoding, ownership
	// ----------------------------------------
	logic tx_raw;
	logic tx_ir;

	always_comb begin
		case (tx_state_q)
			ST_START: tx_raw = 1'b0;
			ST_BITS: tx_raw = tx_shift_q[0];
			default: tx_raw = 1'b1;
		endcase
	end

	assign tx_ir = !tx_raw && (tx_phase < PH_W'(IR_CLKS));

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin <= 1'b1;
			serial_out_en <= 1'b0;
		end else if (clk_en) begin
			serial_out_en <= txen_q; // RQ9
			if (ir_on_q) begin
				serial_out_pin <= tx_ir ^ inv_q; // RQ6
			end else begin
				serial_out_pin <= tx_raw ^ inv_q; // RQ5
			end
		end
	end

	// ----------------------------------------
	// Transmit event selection
	// ----------------------------------------
	function automatic logic tx_event(input logic [1:0] sel, input logic pop, input logic done,
			input logic [CNT_W-1:0] after, input logic brk);
		case (sel)
			TXI_PER_CHAR: tx_event = pop;
			TXI_ALL_DONE: tx_event = done && (after == '0) && !brk;
			TXI_BUF_EMPTY: tx_event = pop && (after == '0);
			default: tx_event = 1'b0;
		endcase
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_irq <= 1'b0;
		end else if (clk_en) begin
			// RQ1 RQ2 RQ3 RQ4
			tx_irq <= tx_event(tx_sel_q, tx_pop, tx_done && txen_q, tx_cnt_after, brk_q && !tx_brk_frame_q);
		end
	end

	// ----------------------------------------
	// Receive shifter
	// ----------------------------------------
	ussc_state_t rx_state_q;
	logic [DATA_W-1:0] rx_shift_q;
	logic [BIT_W-1:0] rx_bit_q;
	logic rx_restart;
	logic rx_half;
	logic rx_stop;
	logic rx_push;
	logic rx_pop;
	logic [DATA_W-1:0] rx_head;
	logic [CNT_W-1:0] rx_cnt;
	logic [CNT_W-1:0] rx_cnt_after;
	logic rx_full;
	logic rx_empty;

	assign rx_restart = (rx_state_q == ST_IDLE) && !serial_in;
	assign rx_stop = clk_en && (rx_state_q == ST_STOP) && rx_half;
	assign rx_push = rx_stop && !rx_full;
	assign rx_pop = clk_en && rd_rxdata && !rx_empty;

	ussc_baud #(
		.CLKS(CLKS),
		.CNT_W(PH_W)
	) u_rx_baud (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.restart(rx_restart),
		.bit_tick(),
		.half_tick(rx_half),
		.phase()
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_q <= ST_IDLE;
			rx_shift_q <= '0;
			rx_bit_q <= '0;
		end else if (clk_en) begin
			case (rx_state_q)
				ST_IDLE: begin
					if (!serial_in) begin
						rx_state_q <= ST_START;
					end
				end
				ST_START: begin
					if (rx_half) begin
						rx_state_q <= serial_in ? ST_IDLE : ST_BITS;
						rx_bit_q <= '0;
					end
				end
				ST_BITS: begin
					if (rx_half) begin
						rx_shift_q <= {serial_in, rx_shift_q[DATA_W-1:1]};
						if (rx_bit_q == BIT_W'(DATA_W - 1)) begin
							rx_state_q <= ST_STOP;
						end else begin
							rx_bit_q <= rx_bit_q + 1'b1;
						end
					end
				end
				ST_STOP: begin
					if (rx_half) begin
						rx_state_q <= ST_IDLE;
					end
				end
				default: begin
					rx_state_q <= ST_IDLE;
				end
			endcase
		end
	end

	ussc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.CNT_W(CNT_W)
	) u_rx_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.flush(1'b0),
		.push(rx_push),
		.wdata(rx_shift_q),
		.pop(rx_pop),
		.rdata(rx_head),
		.count(rx_cnt),
		.full(rx_full),
		.empty(rx_empty)
	);

	assign rx_cnt_after = rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);

	// ----------------------------------------
	// Receive event selection
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_irq <= 1'b0;
		end else if (clk_en) begin
			case (rx_sel_q)
				RXI_FOUR: rx_irq <= rx_push && (rx_cnt_after == CNT_W'(RX_FOUR_CNT)); // RQ14
				RXI_THREE: rx_irq <= rx_push && (rx_cnt_after == CNT_W'(RX_THREE_CNT)); // RQ15
				default: rx_irq <= rx_push; // RQ16
			endcase
		end
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sel_q <= 2'h0;
			inv_q <= 1'b0;
			txen_q <= 1'b0;
			rx_sel_q <= 2'h0;
			ir_on_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_status) begin
				tx_sel_q <= {reg_wdata[B_TXISEL1], reg_wdata[B_TXISEL0]};
				inv_q <= reg_wdata[B_INV];
				txen_q <= reg_wdata[B_TXEN];
				rx_sel_q <= {reg_wdata[B_RXISEL1], reg_wdata[B_RXISEL0]};
			end
			if (wr_mode) begin
				ir_on_q <= reg_wdata[B_IR_ON];
			end
		end
	end

	// Break request: a software set wins over the completion clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_status && reg_wdata[B_BRK]) begin
				brk_q <= 1'b1;
			end else if (tx_done && tx_brk_frame_q) begin
				brk_q <= 1'b0; // RQ8
			end else if (wr_status || !txen_q) begin
				brk_q <= 1'b0;
			end
		end
	end

	// Receive error flags: overrun is cleared by writing zero, set wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oerr_q <= 1'b0;
			ferr_q <= 1'b0;
		end else if (clk_en) begin
			if (rx_stop && rx_full) begin
				oerr_q <= 1'b1;
			end else if (wr_status && !reg_wdata[B_OERR]) begin
				oerr_q <= 1'b0;
			end
			if (rx_push) begin
				ferr_q <= !serial_in;
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [REG_W-1:0] status_word;

	always_comb begin
		status_word = STATUS_RESET;
		status_word[B_TXISEL1] = tx_sel_q[1];
		status_word[B_INV] = inv_q;
		status_word[B_TXISEL0] = tx_sel_q[0];
		status_word[B_UNUSED12] = 1'b0; // RQ17
		status_word[B_BRK] = brk_q;
		status_word[B_TXEN] = txen_q;
		status_word[B_TXBF] = tx_full; // RQ11 RQ18
		status_word[B_TXEMPTY] = tx_empty && (tx_state_q == ST_IDLE); // RQ12 RQ13 RQ18
		status_word[B_RXISEL1] = rx_sel_q[1];
		status_word[B_RXISEL0] = rx_sel_q[0];
		status_word[B_RXIDLE] = (rx_state_q == ST_IDLE);
		status_word[B_PERR] = 1'b0;
		status_word[B_FERR] = ferr_q;
		status_word[B_OERR] = oerr_q;
		status_word[B_RXDA] = !rx_empty;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					REG_STATUS: reg_rdata <= status_word;
					REG_RXDATA: reg_rdata <= REG_W'(rx_head);
					REG_MODE: reg_rdata <= REG_W'(ir_on_q);
					default: reg_rdata <= '0;
				endcase
			end else begin
				reg_rdata <= '0;
			end
		end
	end
endmodule

// file: verilog/ussc_pkg.sv
// Shared constants of the serial port status and control block
// Assumes one 16-bit register word per index on a plain register port
package ussc_pkg;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	localparam int ADDR_W = 2;
	localparam int REG_W = 16;
	localparam int DATA_W = 8;
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_TXDATA = 2'h1;
	localparam logic [1:0] REG_RXDATA = 2'h2;
	localparam logic [1:0] REG_MODE = 2'h3;

	// ----------------------------------------
	// Status and control field positions
	// ----------------------------------------
	localparam int B_TXISEL1 = 15;
	localparam int B_INV = 14;
	localparam int B_TXISEL0 = 13;
	localparam int B_UNUSED12 = 12;
	localparam int B_BRK = 11;
	localparam int B_TXEN = 10;
	localparam int B_TXBF = 9;
	localparam int B_TXEMPTY = 8;
	localparam int B_RXISEL1 = 7;
	localparam int B_RXISEL0 = 6;
	localparam int B_RXIDLE = 4;
	localparam int B_PERR = 3;
	localparam int B_FERR = 2;
	localparam int B_OERR = 1;
	localparam int B_RXDA = 0;
	localparam int B_IR_ON = 0;

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [1:0] {
		TXI_PER_CHAR = 2'b00,
		TXI_ALL_DONE = 2'b01,
		TXI_BUF_EMPTY = 2'b10,
		TXI_RESERVED = 2'b11
	} ussc_txi_t;

	localparam logic [1:0] RXI_THREE = 2'b10;
	localparam logic [1:0] RXI_FOUR = 2'b11;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BITS = 2'b10,
		ST_STOP = 2'b11
	} ussc_state_t;

	// ----------------------------------------
	// Counts
	// ----------------------------------------
	localparam int FIFO_DEPTH = 4;
	localparam int RX_THREE_CNT = 3;
	localparam int RX_FOUR_CNT = 4;
	localparam int BREAK_ZEROS = 12;
	localparam int CLKS_PER_BIT = 16;
	localparam int IR_NUM = 3;
	localparam int IR_DEN = 16;
	localparam logic [REG_W-1:0] STATUS_RESET = 16'h0000;

endpackage

// file: verilog/ussc_fifo.sv
// Flip-flop FIFO used as transmit and receive character buffer
// Assumes the caller never pushes when full nor pops when empty
`timescale 1ns/1ns
module ussc_fifo import ussc_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int CNT_W = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Control
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic pop,
	// State
	output logic [WIDTH-1:0] rdata,
	output logic [CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] rd_q;
	logic [CNT_W-1:0] cnt_q;

	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		ptr_next = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem_q[wr_q] <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wr_q <= '0;
				rd_q <= '0;
				cnt_q <= '0;
			end else begin
				if (push) begin
					wr_q <= ptr_next(wr_q);
				end
				if (pop) begin
					rd_q <= ptr_next(rd_q);
				end
				cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
			end
		end
	end

	assign rdata = mem_q[rd_q];
	assign count = cnt_q;
	assign full = (cnt_q == CNT_W'(DEPTH));
	assign empty = (cnt_q == '0);
endmodule

// file: verilog/ussc_baud.sv
// Bit period timer: end-of-bit and mid-bit ticks plus the phase count
// Assumes restart is raised in the cycle a frame or bit search begins
`timescale 1ns/1ns
module ussc_baud import ussc_pkg::*; #(
	parameter int CLKS = CLKS_PER_BIT,
	parameter int CNT_W = $clog2(CLKS)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Control
	input wire logic restart,
	// Ticks
	output logic bit_tick,
	output logic half_tick,
	output logic [CNT_W-1:0] phase
);
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (restart || bit_tick) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign bit_tick = !restart && (cnt_q == CNT_W'(CLKS - 1));
	assign half_tick = !restart && (cnt_q == CNT_W'(CLKS / 2 - 1));
	assign phase = cnt_q;
endmodule

// file: tb/ussc_checker_assertions.sv
// Port-level checker for the serial port status and control block
// Assumes one clock domain and register writes taken only with clk_en high
`timescale 1ns/1ns
module ussc_checker import ussc_pkg::*; #(
	parameter int CLKS = CLKS_PER_BIT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [REG_W-1:0] reg_rdata,
	// Serial line
	input wire logic serial_out_pin,
	input wire logic serial_out_en,
	input wire logic serial_in,
	// Events
	input wire logic tx_irq,
	input wire logic rx_irq
);
	localparam int BRK_MAX = (BREAK_ZEROS + 1) * CLKS;
	localparam int RX_LO = 9 * CLKS;
	localparam int RX_HI = 10 * CLKS + 4;
	logic inv_q, en_q, ir_on_q, rxs1_q, in_q, st_wr, en_bit;
	int low_q, fr_q;
	assign st_wr = reg_wr && clk_en && reg_addr == REG_STATUS;
	assign en_bit = reg_wdata[B_TXEN];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Shadow of control fields and line counters
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			inv_q <= 1'h0;
			en_q <= 1'h0;
			rxs1_q <= 1'h0;
		end else if (st_wr) begin
			inv_q <= reg_wdata[B_INV];
			en_q <= en_bit;
			rxs1_q <= reg_wdata[B_RXISEL1];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ir_on_q <= 1'h0;
		else if (reg_wr && clk_en && reg_addr == REG_MODE)
			ir_on_q <= reg_wdata[B_IR_ON];
	end
	// Length of a low run on a plain, non-inverted line
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			low_q <= 0;
		else if (serial_out_en && !inv_q && !ir_on_q && !serial_out_pin)
			low_q <= low_q + 1;
		else
			low_q <= 0;
	end
	// Frame window on the receive line, so data edges are not taken as starts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_q <= 1'h1;
			fr_q <= 0;
		end else begin
			in_q <= serial_in;
			if (fr_q != 0)
				fr_q <= fr_q - 1;
			else if (in_q && !serial_in)
				fr_q <= RX_HI;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_status_reply;
		$past(reg_rd) && $past(reg_addr) == REG_STATUS;
	endsequence
	sequence s_push;
		reg_wr && reg_addr == REG_TXDATA && en_q;
	endsequence
	sequence s_stat_rd;
		reg_rd && reg_addr == REG_STATUS;
	endsequence
	sequence s_rx_start;
		fr_q == 0 && in_q && !serial_in && !rxs1_q;
	endsequence
	property p_unused;
		s_status_reply |-> reg_rdata[B_UNUSED12] == 1'h0;
	endproperty
	property p_owner;
		$changed(serial_out_en) |-> $past(st_wr, 2) && $past(en_bit, 2) == serial_out_en;
	endproperty
	property p_idle_plain;
		s_status_reply ##0 (reg_rdata[B_TXEMPTY] && !$past(ir_on_q) && $past(serial_out_en, 2))
			|-> $past(serial_out_pin) == !$past(inv_q);
	endproperty
	property p_idle_ir;
		s_status_reply ##0 (reg_rdata[B_TXEMPTY] && $past(ir_on_q) && $past(serial_out_en, 2))
			|-> $past(serial_out_pin) == $past(inv_q);
	endproperty
	property p_full_busy;
		s_status_reply ##0 reg_rdata[B_TXBF] |-> !reg_rdata[B_TXEMPTY];
	endproperty
	property p_push_busy;
		s_push ##2 s_stat_rd |-> ##1 !reg_rdata[B_TXEMPTY];
	endproperty
	property p_break_len;
		low_q <= BRK_MAX;
	endproperty
	property p_rx_any;
		s_rx_start |-> ##[RX_LO:RX_HI] rx_irq;
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bit read as one");
	a_owner: assert property (p_owner) else $error("pin ownership not following enable");
	a_idle_plain: assert property (p_idle_plain) else $error("plain idle level wrong");
	a_idle_ir: assert property (p_idle_ir) else $error("encoded idle level wrong");
	a_full_busy: assert property (p_full_busy) else $error("full flag with empty flag");
	a_push_busy: assert property (p_push_busy) else $error("empty flag set after push");
	a_break_len: assert property (p_break_len) else $error("low run longer than break");
	a_rx_any: assert property (p_rx_any) else $error("no receive event for character");
endmodule

bind ussc_top ussc_checker #(.CLKS(CLKS)) u_chk (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .serial_out_pin, .serial_out_en, .serial_in, .tx_irq, .rx_irq);

// file: tb/ussc_remote_node.sv
// Remote serial node: sends frames to the block and captures its frames
// Assumes 8 data bits, LSB first, one stop bit, plain non-inverted line
`timescale 1ns/1ns
module ussc_remote_node #(
	parameter int CLKS = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Line from the block
	input wire logic serial_out_pin,
	input wire logic serial_out_en,
	// Line to the block
	output logic serial_in
);
	logic [7:0] got_q [$];
	logic [8:0] b;
	int low_run = 0;
	int last_low = 0;
	initial serial_in = 1'h1;
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] frame;
		frame = {1'h1, d, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			serial_in <= frame[i];
			repeat (CLKS - 1) @(posedge sys_clk);
		end
		// Idle gap of two bits keeps starts apart
		repeat (2 * CLKS) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		if (rst_n === 1'h1 && serial_out_en === 1'h1 && serial_out_pin === 1'h0) begin
			low_run <= low_run + 1;
		end else begin
			if (low_run != 0)
				last_low <= low_run;
			low_run <= 0;
		end
	end
	initial begin
		forever begin
			@(posedge sys_clk);
			if (rst_n === 1'h1 && serial_out_en === 1'h1 && serial_out_pin === 1'h0) begin
				repeat (CLKS / 2) @(posedge sys_clk);
				for (int i = 0; i < 9; i++) begin
					repeat (CLKS) @(posedge sys_clk);
					b = {serial_out_pin, b[8:1]};
				end
				if (b[8] === 1'h1)
					got_q.push_back(b[7:0]);
				while (serial_out_pin === 1'h0) @(posedge sys_clk);
			end
		end
	end
endmodule

// file: tb/uart_status_control_tb_top.sv
// Self-checking bench for the serial port status and control block
// Assumes the remote node model on the line and a 100 MHz clock
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module uart_status_control_tb_top import ussc_pkg::*;;
	localparam int CK = 4;
	logic sys_clk, rst_n, clk_en, reg_wr, reg_rd, serial_in, serial_out_pin, serial_out_en, tx_irq, rx_irq;
	logic [ADDR_W-1:0] reg_addr;
	logic [REG_W-1:0] reg_wdata, reg_rdata, rd;
	int fails, num_checks, tx_n, rx_n, base;
	ussc_top #(.CLKS(CK), .DEPTH(FIFO_DEPTH)) DUT (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .serial_out_pin, .serial_out_en, .serial_in, .tx_irq, .rx_irq);
	ussc_remote_node #(.CLKS(CK)) u_node (.sys_clk, .rst_n, .serial_out_pin, .serial_out_en, .serial_in);
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (tx_irq === 1'h1) tx_n++;
		if (rx_irq === 1'h1) rx_n++;
	end
	// ----------------------------------------
	// Register access and helpers
	// ----------------------------------------
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdr(input logic [1:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 rd = reg_rdata;
	endtask
	function automatic logic [15:0] st(input logic [1:0] txs, input logic inv, input logic brk,
		input logic [1:0] rxs);
		st = 16'h0000;
		st[B_TXISEL1] = txs[1];
		st[B_TXISEL0] = txs[0];
		st[B_INV] = inv;
		st[B_BRK] = brk;
		st[B_TXEN] = 1'h1;
		st[B_RXISEL1] = rxs[1];
		st[B_RXISEL0] = rxs[0];
	endfunction
	task automatic wait_idle;
		for (int i = 0; i < 300; i++) begin
			rdr(REG_STATUS);
			if (rd[B_TXEMPTY] === 1'h1) break;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdr(REG_STATUS);
		`CHK("status after reset", 16'h0110, rd)
		$display("test reset done");
	endtask
	task automatic t_tx;
		logic [1:0] sel [3] = '{2'h0, 2'h1, 2'h2};
		int exp_irq [3] = '{5, 1, 2};
		for (int s = 0; s < 3; s++) begin
			u_node.got_q.delete();
			wr(REG_STATUS, st(sel[s], 1'h0, 1'h0, 2'h0));
			base = tx_n;
			wr(REG_TXDATA, 16'h00A0);
			repeat (3) @(posedge sys_clk);
			for (int i = 1; i < 5; i++) wr(REG_TXDATA, 16'h00A0 + 16'(i));
			rdr(REG_STATUS);
			`CHK("full flag", 1'h1, rd[B_TXBF])
			`CHK("empty flag busy", 1'h0, rd[B_TXEMPTY])
			wait_idle();
			repeat (4) @(posedge sys_clk);
			`CHK("tx event count", exp_irq[s], tx_n - base)
			`CHK("flags when idle", 2'h1, {rd[B_TXBF], rd[B_TXEMPTY]})
			for (int i = 0; i < 5; i++) `CHK("tx byte", 8'hA0 + 8'(i), u_node.got_q[i])
		end
		$display("test tx events done");
	endtask
	task automatic t_break;
		wr(REG_STATUS, st(2'h0, 1'h0, 1'h1, 2'h0));
		for (int i = 0; i < 100; i++) begin
			rdr(REG_STATUS);
			if (rd[B_BRK] === 1'h0) break;
		end
		repeat (2 * CK) @(posedge sys_clk);
		`CHK("break cleared", 1'h0, rd[B_BRK])
		`CHK("break low length", (BREAK_ZEROS + 1) * CK, u_node.last_low)
		$display("test break done");
	endtask
	task automatic t_disable;
		wr(REG_STATUS, st(2'h0, 1'h0, 1'h0, 2'h0));
		for (int i = 0; i < 3; i++) wr(REG_TXDATA, 16'h0055 + 16'(i));
		repeat (3 * CK) @(posedge sys_clk);
		wr(REG_STATUS, 16'h0000);
		repeat (2) @(posedge sys_clk);
		#1 `CHK("pin released", 1'h0, serial_out_en)
		wr(REG_STATUS, st(2'h0, 1'h0, 1'h0, 2'h0));
		repeat (2 * CK) @(posedge sys_clk);
		rdr(REG_STATUS);
		`CHK("buffer flushed", 2'h1, {rd[B_TXBF], rd[B_TXEMPTY]})
		$display("test disable done");
	endtask
	task automatic t_rx;
		logic [1:0] sel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
		int n [4] = '{1, 1, 3, 4};
		for (int s = 0; s < 4; s++) begin
			wr(REG_STATUS, st(2'h0, 1'h0, 1'h0, sel[s]));
			base = rx_n;
			for (int i = 0; i < n[s]; i++) begin
				`CHK("rx event early", 0, rx_n - base)
				u_node.send_byte(8'h30 + 8'(i));
			end
			`CHK("rx event count", 1, rx_n - base)
			for (int i = 0; i < n[s]; i++) begin
				rdr(REG_RXDATA);
				`CHK("rx byte", 16'h0030 + 16'(i), rd)
			end
		end
		$display("test rx events done");
	endtask
	task automatic t_polarity;
		for (int k = 0; k < 4; k++) begin
			wr(REG_MODE, 16'(k[1]));
			wr(REG_STATUS, st(2'h0, k[0], 1'h0, 2'h0));
			repeat (CK) @(posedge sys_clk);
			rdr(REG_STATUS);
			`CHK("idle level", k[0] ^ !k[1], serial_out_pin)
		end
		// A write while the clock enable is low must leave every field as it was
		@(posedge sys_clk);
		clk_en <= 1'h0;
		wr(REG_STATUS, 16'h0000);
		clk_en <= 1'h1;
		rdr(REG_STATUS);
		`CHK("frozen write", 1'h1, rd[B_TXEN])
		$display("test polarity done");
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		rst_n = 1'h0;
		clk_en = 1'h1;
		fails = 0;
		num_checks = 0;
		tx_n = 0;
		rx_n = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'h1;
		t_reset();
		t_tx();
		t_break();
		t_disable();
		t_rx();
		t_polarity();
		end_of_test();
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end
endmodule
